/* hdl/ddr_dll_pkg.sv */
//////////////////////////////////////////////////////////////////////
//////////////////////////////////////////////////////////////////////
package ddr_dll_pkg;

	// Clock and timing figures.
	localparam int CLK_PERIOD_NS = 10;
	localparam int T_CKSRE_NS = 10;
	localparam int T_CKSRX_NS = 10;
	localparam int T_XS_NS = 170;
	localparam int T_MOD_CK = 12;
	localparam int T_MRD_CK = 4;
	localparam int T_DLLK_CK = 512;
	localparam int T_ZQOPER_CK = 512;

	// Rounds a time up to whole cycles, never below one.
	function automatic int ns_to_cyc(input int ns);
		int c;
		c = (ns + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
		return (c < 1) ? 1 : c;
	endfunction : ns_to_cyc

	localparam int T_CKSRE_CK = ns_to_cyc(T_CKSRE_NS);
	localparam int T_CKSRX_CK = ns_to_cyc(T_CKSRX_NS);
	localparam int T_XS_CK = ns_to_cyc(T_XS_NS);

	// Command codes on {RAS#, CAS#, WE#}.
	localparam logic [2:0] CMD_MRS = 3'h0;
	localparam logic [2:0] CMD_REF = 3'h1;
	localparam logic [2:0] CMD_READ = 3'h5;
	localparam logic [2:0] CMD_ZQ = 3'h6;
	localparam logic [2:0] CMD_NOP = 3'h7;

	// Mode register fields.
	localparam int MR1_DLL_DIS_BIT = 0;
	localparam int MR0_DLL_RST_BIT = 8;
	localparam int MR0_CL_LSB = 4;
	localparam int MR1_AL_LSB = 3;
	localparam int ADDR_ZQ_LONG_BIT = 10;
	localparam logic [13:0] MR0_RESET = 14'h0020;
	localparam logic [13:0] MR1_RESET = 14'h0000;

	// Controller registers on APB.
	localparam logic [7:0] REG_CTRL = 8'h00;
	localparam logic [7:0] REG_MR0 = 8'h04;
	localparam logic [7:0] REG_STATUS = 8'h08;
	localparam logic [7:0] REG_READ = 8'h0c;
	localparam logic [7:0] REG_RDATA = 8'h10;
	localparam int CTRL_GO = 0;
	localparam int CTRL_OFF = 1;
	localparam int CTRL_ZQ = 2;
	localparam int ST_BUSY = 0;
	localparam int ST_DONE = 1;
	localparam int ST_DLL_OFF = 2;
	localparam int ST_RVALID = 3;

	// Controller sequencer states.
	typedef enum logic [10:0] {
		C_IDLE = 11'h001,
		C_MR1 = 11'h002,
		C_SRE = 11'h004,
		C_FREQ = 11'h008,
		C_SRX = 11'h010,
		C_MR0RST = 11'h020,
		C_MRUPD = 11'h040,
		C_ZQ = 11'h080,
		C_LOCK = 11'h100,
		C_READ = 11'h200,
		C_WAIT = 11'h400
	} ctl_state_t;

endpackage : ddr_dll_pkg

/* hdl/ddr_link_if.sv */
`timescale 1ns/100ps
`default_nettype none
// Command pins from controller, read strobe and data from device.
interface ddr_link_if;
	logic cke;
	logic cs_n;
	logic ras_n;
	logic cas_n;
	logic we_n;
	logic [2:0] ba;
	logic [13:0] a;
	logic odt;
	logic dqs;
	logic [15:0] dq;
	modport ctl (output cke, cs_n, ras_n, cas_n, we_n, ba, a, odt, input dqs, dq);
	modport dev (input cke, cs_n, ras_n, cas_n, we_n, ba, a, odt, output dqs, dq);
endinterface : ddr_link_if
`default_nettype wire

/* hdl/ddr_dev.sv */
`timescale 1ns/100ps
`default_nettype none
module ddr_dev (
	// Clock and reset.
	input wire logic I_MCLK,
	input wire logic I_NRST,
	// Link to the controller.
	ddr_link_if.dev link,
	// Status seen by the user.
	output logic O_DLL_OFF,
	output logic O_SELF_REFRESH,
	output logic O_DLL_LOCKED
);

	typedef struct packed {
		logic [13:0] mr0;
		logic [13:0] mr1;
		logic sr;
		logic cke_prev;
		logic [9:0] dllk;
		logic locked;
		logic [31:0] pipe;
		logic [15:0] rcol;
		logic dqs;
		logic [15:0] dq;
	} dev_t;

	dev_t s_q;
	dev_t s_d;
	logic cmd_ok;
	logic [2:0] cmd;
	logic [4:0] lat;

	// Read latency in cycles; DLL off brings the strobe one cycle forward.
	function automatic logic [4:0] read_lat(input logic [13:0] m0, input logic [13:0] m1);
		logic [4:0] cl;
		logic [4:0] al;
		cl = {2'h0, m0[ddr_dll_pkg::MR0_CL_LSB +: 3]} + 5'h04;
		case (m1[ddr_dll_pkg::MR1_AL_LSB +: 2])
			2'h1: al = cl - 5'h01;
			2'h2: al = cl - 5'h02;
			default: al = 5'h00;
		endcase
		if (m1[ddr_dll_pkg::MR1_DLL_DIS_BIT]) begin
			return al + cl - 5'h01;
		end
		return al + cl;
	endfunction : read_lat

	// Only a selected, clock-enabled, non-refreshing cycle decodes a command.
	assign cmd_ok = !link.cs_n && link.cke && s_q.cke_prev && !s_q.sr;
	assign cmd = {link.ras_n, link.cas_n, link.we_n};
	assign lat = read_lat(s_q.mr0, s_q.mr1);

	//////////////////////////////////////////////////////////////////
	// Next state.
	always_comb begin
		s_d = s_q;
		s_d.cke_prev = link.cke;
		s_d.pipe = {s_q.pipe[30:0], 1'b0};
		if (s_q.dllk != 10'h000) begin
			s_d.dllk = s_q.dllk - 10'h001;
		end
		// Self-refresh exit once CKE returns; entry is a refresh with CKE falling.
		if (s_q.sr && link.cke) begin
			s_d.sr = 1'b0;
		end else if (!link.cs_n && s_q.cke_prev && !link.cke && !s_q.sr && cmd == ddr_dll_pkg::CMD_REF) begin
			s_d.sr = 1'b1;
		end
		if (cmd_ok) begin
			case (cmd)
				ddr_dll_pkg::CMD_MRS: begin
					if (link.ba == 3'h0) begin
						s_d.mr0 = link.a;
						if (link.a[ddr_dll_pkg::MR0_DLL_RST_BIT]) begin
							s_d.dllk = 10'(ddr_dll_pkg::T_DLLK_CK);
						end
					end else if (link.ba == 3'h1) begin
						s_d.mr1 = link.a;
					end
				end
				ddr_dll_pkg::CMD_READ: begin
					s_d.pipe[0] = 1'b1;
					s_d.rcol = {2'h0, link.a};
				end
				default: begin
					s_d.mr0 = s_q.mr0;
				end
			endcase
		end
		// Strobe and data leave in the same cycle, so their skew is zero.
		s_d.dqs = s_q.pipe[lat - 5'h01];
		s_d.dq = s_q.pipe[lat - 5'h01] ? ~s_q.rcol : 16'h0000;
		// Lock follows the values being registered, so it rises on the very edge at which tDLLK ends.
		s_d.locked = !s_d.mr1[ddr_dll_pkg::MR1_DLL_DIS_BIT] && (s_d.dllk == 10'h000);
	end

	//////////////////////////////////////////////////////////////////
	// State register.
	always_ff @(posedge I_MCLK) begin
		if (!I_NRST) begin
			s_q <= '{mr0: ddr_dll_pkg::MR0_RESET, mr1: ddr_dll_pkg::MR1_RESET, default: '0};
		end else begin
			s_q <= s_d;
		end
	end

	// Outputs straight from flops.
	assign link.dqs = s_q.dqs;
	assign link.dq = s_q.dq;
	assign O_DLL_OFF = s_q.mr1[ddr_dll_pkg::MR1_DLL_DIS_BIT];
	assign O_SELF_REFRESH = s_q.sr;
	assign O_DLL_LOCKED = s_q.locked;

endmodule : ddr_dev
`default_nettype wire

/* hdl/ddr_ctl.sv */
`timescale 1ns/100ps
`default_nettype none
module ddr_ctl (
	// Clock and reset.
	input wire logic I_MCLK,
	input wire logic I_NRST,
	// APB slave.
	input wire logic I_PSEL,
	input wire logic I_PENABLE,
	input wire logic I_PWRITE,
	input wire logic [7:0] I_PADDR,
	input wire logic [31:0] I_PWDATA,
	output logic O_PREADY,
	output logic O_PSLVERR,
	output logic [31:0] O_PRDATA,
	// Clock-change handshake with the clock generator.
	input wire logic I_CLK_STABLE,
	output logic O_CLK_CHANGE,
	// Link to the memory.
	ddr_link_if.ctl link
);

	typedef struct packed {
		ddr_dll_pkg::ctl_state_t st;
		ddr_dll_pkg::ctl_state_t ret;
		logic [9:0] cnt;
		logic [9:0] dllk;
		logic off_tgt;
		logic zq_en;
		logic done;
		logic dll_off;
		logic rvalid;
		logic [13:0] mr0;
		logic [13:0] rcol;
		logic [15:0] rdata;
		logic cke;
		logic cs_n;
		logic [2:0] cmd;
		logic [2:0] ba;
		logic [13:0] a;
		logic clkreq;
		logic pready;
		logic pslverr;
		logic [31:0] prdata;
	} ctl_t;

	ctl_t s_q;
	ctl_t s_d;
	logic acc;
	logic wr_take;
	logic busy;

	// Access phase, and the edge at which a write lands.
	assign acc = I_PSEL && I_PENABLE;
	assign wr_take = acc && s_q.pready && I_PWRITE && !s_q.pslverr;
	assign busy = (s_q.st != ddr_dll_pkg::C_IDLE);

	// True for the offsets that this block answers.
	function automatic logic mapped(input logic [7:0] ad);
		return ad == ddr_dll_pkg::REG_CTRL || ad == ddr_dll_pkg::REG_MR0 || ad == ddr_dll_pkg::REG_STATUS
			|| ad == ddr_dll_pkg::REG_READ || ad == ddr_dll_pkg::REG_RDATA;
	endfunction : mapped

	//////////////////////////////////////////////////////////////////
	// Next state: sequencer, link pins and APB answers.
	always_comb begin
		s_d = s_q;
		// Pins default to a deselect so nothing stray is registered.
		s_d.cs_n = 1'b1;
		s_d.cmd = ddr_dll_pkg::CMD_NOP;
		s_d.ba = 3'h0;
		s_d.a = 14'h0000;
		if (s_q.dllk != 10'h000) begin
			s_d.dllk = s_q.dllk - 10'h001;
		end
		// Every wait counts actual clock edges.
		if (s_q.cnt != 10'h000) begin
			s_d.cnt = s_q.cnt - 10'h001;
		end
		case (s_q.st)
			ddr_dll_pkg::C_IDLE: begin
				// Software only starts a switch with banks idle and ODT low.
				if (wr_take && I_PADDR == ddr_dll_pkg::REG_CTRL && I_PWDATA[ddr_dll_pkg::CTRL_GO]) begin
					s_d.off_tgt = I_PWDATA[ddr_dll_pkg::CTRL_OFF];
					s_d.zq_en = I_PWDATA[ddr_dll_pkg::CTRL_ZQ];
					s_d.st = I_PWDATA[ddr_dll_pkg::CTRL_OFF] ? ddr_dll_pkg::C_MR1 : ddr_dll_pkg::C_SRE;
				end else if (wr_take && I_PADDR == ddr_dll_pkg::REG_READ) begin
					s_d.rcol = I_PWDATA[13:0];
					s_d.st = ddr_dll_pkg::C_READ;
				end
			end
			ddr_dll_pkg::C_MR1: begin
				// DLL bit follows the target: one to switch off, zero to switch on.
				s_d.cs_n = 1'b0;
				s_d.cmd = ddr_dll_pkg::CMD_MRS;
				s_d.ba = 3'h1;
				s_d.a[ddr_dll_pkg::MR1_DLL_DIS_BIT] = s_q.off_tgt;
				s_d.dll_off = s_q.off_tgt;
				s_d.cnt = 10'(s_q.off_tgt ? ddr_dll_pkg::T_MOD_CK - 1 : ddr_dll_pkg::T_MRD_CK - 1);
				s_d.ret = s_q.off_tgt ? ddr_dll_pkg::C_SRE : ddr_dll_pkg::C_MR0RST;
				s_d.st = ddr_dll_pkg::C_WAIT;
			end
			ddr_dll_pkg::C_SRE: begin
				// Refresh with CKE falling enters self refresh.
				s_d.cs_n = 1'b0;
				s_d.cmd = ddr_dll_pkg::CMD_REF;
				s_d.cke = 1'b0;
				s_d.cnt = 10'(ddr_dll_pkg::T_CKSRE_CK - 1);
				s_d.ret = ddr_dll_pkg::C_FREQ;
				s_d.st = ddr_dll_pkg::C_WAIT;
			end
			ddr_dll_pkg::C_FREQ: begin
				// The clock generator retunes; the DLL-off rate is its concern.
				s_d.clkreq = 1'b1;
				if (s_q.clkreq && I_CLK_STABLE) begin
					s_d.clkreq = 1'b0;
					s_d.cnt = 10'(ddr_dll_pkg::T_CKSRX_CK - 1);
					s_d.ret = ddr_dll_pkg::C_SRX;
					s_d.st = ddr_dll_pkg::C_WAIT;
				end
			end
			ddr_dll_pkg::C_SRX: begin
				// CKE rises with a NOP and stays high to the end of the switch.
				s_d.cs_n = 1'b0;
				s_d.cke = 1'b1;
				s_d.cnt = 10'(ddr_dll_pkg::T_XS_CK - 1);
				s_d.ret = s_q.off_tgt ? ddr_dll_pkg::C_MRUPD : ddr_dll_pkg::C_MR1;
				s_d.st = ddr_dll_pkg::C_WAIT;
			end
			ddr_dll_pkg::C_MR0RST: begin
				s_d.cs_n = 1'b0;
				s_d.cmd = ddr_dll_pkg::CMD_MRS;
				s_d.a = s_q.mr0;
				s_d.a[ddr_dll_pkg::MR0_DLL_RST_BIT] = 1'b1;
				s_d.dllk = 10'(ddr_dll_pkg::T_DLLK_CK);
				s_d.cnt = 10'(ddr_dll_pkg::T_MRD_CK - 1);
				s_d.ret = ddr_dll_pkg::C_MRUPD;
				s_d.st = ddr_dll_pkg::C_WAIT;
			end
			ddr_dll_pkg::C_MRUPD: begin
				// Latency update; in DLL-off mode software supplies CL six.
				s_d.cs_n = 1'b0;
				s_d.cmd = ddr_dll_pkg::CMD_MRS;
				s_d.a = s_q.mr0;
				s_d.a[ddr_dll_pkg::MR0_DLL_RST_BIT] = 1'b0;
				s_d.cnt = 10'(ddr_dll_pkg::T_MOD_CK - 1);
				s_d.ret = s_q.zq_en ? ddr_dll_pkg::C_ZQ : ddr_dll_pkg::C_LOCK;
				s_d.st = ddr_dll_pkg::C_WAIT;
			end
			ddr_dll_pkg::C_ZQ: begin
				s_d.cs_n = 1'b0;
				s_d.cmd = ddr_dll_pkg::CMD_ZQ;
				s_d.a[ddr_dll_pkg::ADDR_ZQ_LONG_BIT] = 1'b1;
				s_d.cnt = 10'(ddr_dll_pkg::T_ZQOPER_CK - 1);
				s_d.ret = ddr_dll_pkg::C_LOCK;
				s_d.st = ddr_dll_pkg::C_WAIT;
			end
			ddr_dll_pkg::C_LOCK: begin
				// Nothing needing a locked DLL goes out before the lock time.
				if (s_q.dllk == 10'h000) begin
					s_d.done = 1'b1;
					s_d.st = ddr_dll_pkg::C_IDLE;
				end
			end
			ddr_dll_pkg::C_READ: begin
				s_d.cs_n = 1'b0;
				s_d.cmd = ddr_dll_pkg::CMD_READ;
				s_d.a = s_q.rcol;
				s_d.st = ddr_dll_pkg::C_IDLE;
			end
			ddr_dll_pkg::C_WAIT: begin
				if (s_q.cnt == 10'h000) begin
					s_d.st = s_q.ret;
				end
			end
			default: begin
				s_d.st = ddr_dll_pkg::C_IDLE;
			end
		endcase
		// Read capture; strobe and data arrive together.
		if (link.dqs) begin
			s_d.rdata = link.dq;
			s_d.rvalid = 1'b1;
		end
		// Register writes; clearing a flag loses to a new event in the same cycle.
		if (wr_take) begin
			case (I_PADDR)
				ddr_dll_pkg::REG_MR0: begin
					s_d.mr0 = I_PWDATA[13:0];
				end
				ddr_dll_pkg::REG_STATUS: begin
					if (I_PWDATA[ddr_dll_pkg::ST_DONE] && !(s_q.st == ddr_dll_pkg::C_LOCK && s_q.dllk == 10'h000)) begin
						s_d.done = 1'b0;
					end
					if (I_PWDATA[ddr_dll_pkg::ST_RVALID] && !link.dqs) begin
						s_d.rvalid = 1'b0;
					end
				end
				default: begin
					s_d.rvalid = s_d.rvalid;
				end
			endcase
		end
		// One wait state: pready rises on the second access cycle.
		s_d.pready = acc && !s_q.pready;
		s_d.pslverr = acc && !s_q.pready && !mapped(I_PADDR);
		s_d.prdata = 32'h0000_0000;
		if (acc && !s_q.pready && !I_PWRITE) begin
			case (I_PADDR)
				ddr_dll_pkg::REG_CTRL: begin
					s_d.prdata = {29'h0, s_q.zq_en, s_q.off_tgt, 1'b0};
				end
				ddr_dll_pkg::REG_MR0: begin
					s_d.prdata = {18'h0, s_q.mr0};
				end
				ddr_dll_pkg::REG_STATUS: begin
					s_d.prdata = {28'h0, s_q.rvalid, s_q.dll_off, s_q.done, busy};
				end
				ddr_dll_pkg::REG_RDATA: begin
					s_d.prdata = {16'h0, s_q.rdata};
				end
				default: begin
					s_d.prdata = 32'h0000_0000;
				end
			endcase
		end
	end

	//////////////////////////////////////////////////////////////////
	// State register; CKE low under reset as at power-up.
	always_ff @(posedge I_MCLK) begin
		if (!I_NRST) begin
			s_q <= '{st: ddr_dll_pkg::C_IDLE, ret: ddr_dll_pkg::C_IDLE, cs_n: 1'b1, cmd: ddr_dll_pkg::CMD_NOP,
				mr0: ddr_dll_pkg::MR0_RESET, default: '0};
		end else begin
			s_q <= s_d;
		end
	end

	// Outputs straight from flops; ODT is held low throughout.
	assign link.cke = s_q.cke;
	assign link.cs_n = s_q.cs_n;
	assign link.ras_n = s_q.cmd[2];
	assign link.cas_n = s_q.cmd[1];
	assign link.we_n = s_q.cmd[0];
	assign link.ba = s_q.ba;
	assign link.a = s_q.a;
	assign link.odt = 1'b0;
	assign O_CLK_CHANGE = s_q.clkreq;
	assign O_PREADY = s_q.pready;
	assign O_PSLVERR = s_q.pslverr;
	assign O_PRDATA = s_q.prdata;

endmodule : ddr_ctl
`default_nettype wire

/* bench/ddr_link_chk.sv */
`timescale 1ns/100ps
`default_nettype none
////////////////////////////////////////////////////////////////////////
// Watches the link between the controller and the memory.
module ddr_link_chk (
	// Clock and reset.
	input wire logic I_MCLK,
	input wire logic I_NRST,
	// Link signals.
	input wire logic cke,
	input wire logic cs_n,
	input wire logic ras_n,
	input wire logic cas_n,
	input wire logic we_n,
	input wire logic [2:0] ba,
	input wire logic [13:0] a,
	input wire logic odt,
	input wire logic dqs,
	input wire logic [15:0] dq
);
	default clocking cb @(posedge I_MCLK);
	endclocking
	default disable iff (!I_NRST);
	logic cke_q;
	logic off_q;
	logic [13:0] col_q;
	logic sel;
	logic rd;
	logic mrs;
	logic sre;
	// Reads and mode writes count only while the clock enable has been high for two edges.
	assign sel = cke && cke_q && !cs_n;
	assign rd = sel && {ras_n, cas_n, we_n} == ddr_dll_pkg::CMD_READ;
	assign mrs = sel && {ras_n, cas_n, we_n} == ddr_dll_pkg::CMD_MRS;
	assign sre = !cs_n && {ras_n, cas_n, we_n} == ddr_dll_pkg::CMD_REF && !cke && cke_q;
	// Tracks the DLL mode and the last read column as the memory should see them.
	always_ff @(posedge I_MCLK) begin
		if (!I_NRST) begin
			cke_q <= 1'b0;
			off_q <= 1'b0;
			col_q <= 14'h0000;
		end else begin
			cke_q <= cke;
			if (mrs && ba == 3'h1) begin
				off_q <= a[0];
			end
			if (rd) begin
				col_q <= a;
			end
		end
	end
	////////////////////////////////////////////////////////////////////////
	a_strobe_cause: assert property (dqs |-> $past(rd, 6) || $past(rd, 7)) else $error("strobe without read");
	a_read_lat_on: assert property (rd && !off_q |-> ##7 dqs) else $error("read latency with DLL on");
	a_read_lat_off: assert property (rd && off_q |-> ##6 dqs) else $error("read latency with DLL off");
	a_dq_value: assert property (dqs |-> dq[13:0] == ~col_q) else $error("read data wrong");
	a_dq_quiet: assert property (!dqs |-> dq == 16'h0000) else $error("data outside strobe");
	a_odt_off: assert property (!odt) else $error("termination raised");
	a_srx_cke_hold: assert property ($rose(cke) |-> cke[*8]) else $error("clock enable dropped");
	a_srx_quiet: assert property ($rose(cke) |=> (cs_n || {ras_n, cas_n, we_n} == ddr_dll_pkg::CMD_NOP)[*8])
		else $error("command too soon after exit");
	a_mrs_spacing: assert property (mrs |=> (!mrs)[*3]) else $error("mode writes too close");
	a_dis_to_sre: assert property (mrs && ba == 3'h1 && a[0] |=> (cke && !mrs)[*8] ##[4:12] sre)
		else $error("self refresh timing after disable");
	a_dll_rst: assert property (mrs && ba == 3'h1 && !a[0] |-> ##[4:8] (mrs && ba == 3'h0 && a[8]))
		else $error("no DLL reset after enable");
	// Main scenarios.
	c_read_off: cover property (rd && off_q);
	c_sre: cover property (sre);
	c_dll_rst: cover property (mrs && ba == 3'h0 && a[8]);
endmodule : ddr_link_chk
`default_nettype wire

/* bench/ddr_dll_off_mode_sequencing_tb.sv */
`timescale 1ns/100ps
`default_nettype none
////////////////////////////////////////////////////////////////////////
// Controller and memory face each other; software steps come over APB.
module ddr_dll_off_mode_sequencing_tb;
	logic clk;
	logic nrst;
	logic psel;
	logic penable;
	logic pwr;
	logic [7:0] paddr;
	logic [31:0] pwdata;
	logic pready;
	logic pslverr;
	logic [31:0] prdata;
	logic clk_stable;
	logic clk_change;
	logic dll_off;
	logic sref;
	logic locked;
	logic saw_sr;
	int n_mismatch;
	int total_checks;
	ddr_link_if link();
	ddr_ctl i_ddr_ctl(.I_MCLK(clk), .I_NRST(nrst), .I_PSEL(psel), .I_PENABLE(penable), .I_PWRITE(pwr),
		.I_PADDR(paddr), .I_PWDATA(pwdata), .O_PREADY(pready), .O_PSLVERR(pslverr), .O_PRDATA(prdata),
		.I_CLK_STABLE(clk_stable), .O_CLK_CHANGE(clk_change), .link(link));
	ddr_dev i_ddr_dev(.I_MCLK(clk), .I_NRST(nrst), .link(link), .O_DLL_OFF(dll_off),
		.O_SELF_REFRESH(sref), .O_DLL_LOCKED(locked));
	ddr_link_chk i_ddr_link_chk(.I_MCLK(clk), .I_NRST(nrst), .cke(link.cke), .cs_n(link.cs_n),
		.ras_n(link.ras_n), .cas_n(link.cas_n), .we_n(link.we_n), .ba(link.ba), .a(link.a),
		.odt(link.odt), .dqs(link.dqs), .dq(link.dq));
	////////////////////////////////////////////////////////////////////////
	// Clock source settles one cycle after a change is asked for.
	initial begin
		clk = 1'b0;
		forever #5 clk = ~clk;
	end
	// One process owns both flags, so reset clears them without a second driver.
	always @(posedge clk) begin
		if (!nrst) begin
			clk_stable <= 1'b0;
			saw_sr <= 1'b0;
		end else begin
			clk_stable <= clk_change;
			if (sref === 1'b1) begin
				saw_sr <= 1'b1;
			end
		end
	end
	task automatic report_and_stop();
		if (n_mismatch == 0 && total_checks > 0) begin
			$display("SIMULATION PASSED");
		end else begin
			$display("SIMULATION FAILED");
		end
		$finish;
	endtask : report_and_stop
	task automatic chk(input string name, input logic [31:0] exp, input logic [31:0] got);
		total_checks++;
		if (got !== exp) begin
			n_mismatch++;
			$display("[ERR] %s expected %h seen %h", name, exp, got);
		end
	endtask : chk
	// One APB transfer; the request stands until pready is seen high.
	task automatic apb(input logic wr, input logic [7:0] ad, input logic [31:0] wd, output logic [31:0] v,
		output logic e);
		int n;
		@(posedge clk);
		psel <= 1'b1;
		pwr <= wr;
		paddr <= ad;
		pwdata <= wd;
		@(posedge clk);
		penable <= 1'b1;
		for (n = 0; n < 20; n++) begin
			@(posedge clk);
			if (pready === 1'b1) break;
		end
		v = prdata;
		e = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
		if (n == 20) begin
			n_mismatch++;
			report_and_stop();
		end
	endtask : apb
	task automatic wr(input logic [7:0] ad, input logic [31:0] wd);
		logic [31:0] v;
		logic e;
		apb(1'b1, ad, wd, v, e);
	endtask : wr
	task automatic rdchk(input string name, input logic [7:0] ad, input logic [31:0] exp);
		logic [31:0] v;
		logic e;
		apb(1'b0, ad, 32'h00000000, v, e);
		chk(name, exp, v);
	endtask : rdchk
	// Polls a status bit; a switch that never ends fails the run at the bound.
	task automatic wait_st(input int b);
		logic [31:0] v;
		logic e;
		for (int k = 0; k < 1000; k++) begin
			apb(1'b0, ddr_dll_pkg::REG_STATUS, 32'h00000000, v, e);
			if (v[b] === 1'b1) return;
		end
		n_mismatch++;
		report_and_stop();
	endtask : wait_st
	task automatic read_col(input logic [13:0] col);
		logic [31:0] v;
		logic e;
		wr(ddr_dll_pkg::REG_READ, {18'h00000, col});
		wait_st(ddr_dll_pkg::ST_RVALID);
		apb(1'b0, ddr_dll_pkg::REG_RDATA, 32'h00000000, v, e);
		chk("rdata", {18'h00000, ~col}, {18'h00000, v[13:0]});
	endtask : read_col
	////////////////////////////////////////////////////////////////////////
	// Reset, then DLL on, DLL off with calibration, and DLL on again.
	initial begin
		logic [31:0] v;
		logic e;
		nrst = 1'b0;
		psel = 1'b0;
		penable = 1'b0;
		pwr = 1'b0;
		paddr = 8'h00;
		pwdata = 32'h00000000;
		n_mismatch = 0;
		total_checks = 0;
		repeat (2) @(posedge clk);
		nrst <= 1'b1;
		rdchk("status", ddr_dll_pkg::REG_STATUS, 32'h00000000);
		rdchk("mr0", ddr_dll_pkg::REG_MR0, 32'h00000020);
		apb(1'b0, 8'h40, 32'h00000000, v, e);
		chk("unmapped", 32'h00000001, 32'(e));
		wr(ddr_dll_pkg::REG_CTRL, 32'h00000001);
		wait_st(ddr_dll_pkg::ST_DONE);
		chk("locked", 32'h00000001, 32'(locked));
		read_col(14'h0155);
		wr(ddr_dll_pkg::REG_STATUS, 32'h0000000a);
		rdchk("status", ddr_dll_pkg::REG_STATUS, 32'h00000000);
		wr(ddr_dll_pkg::REG_CTRL, 32'h00000007);
		wait_st(ddr_dll_pkg::ST_DONE);
		chk("dll off", 32'h00000001, 32'(dll_off));
		chk("unlocked", 32'h00000000, 32'(locked));
		chk("self refresh seen", 32'h00000001, 32'(saw_sr));
		chk("self refresh left", 32'h00000000, 32'(sref));
		chk("clk change idle", 32'h00000000, 32'(clk_change));
		rdchk("status", ddr_dll_pkg::REG_STATUS, 32'h00000006);
		read_col(14'h2aaa);
		wr(ddr_dll_pkg::REG_STATUS, 32'h0000000a);
		wr(ddr_dll_pkg::REG_CTRL, 32'h00000001);
		wait_st(ddr_dll_pkg::ST_DONE);
		chk("dll on", 32'h00000000, 32'(dll_off));
		chk("relocked", 32'h00000001, 32'(locked));
		read_col(14'h3c0f);
		report_and_stop();
	end
endmodule : ddr_dll_off_mode_sequencing_tb
`default_nettype wire
